// file: core/standby_halt_stop_control.sv
// standby sequencer: clock-halted and deep-sleep entry, release and clock gating
// assumes cpu and interrupt controller on clk; extSubClkIn is an outside pin
// How it works
// - an unmasked pending interrupt releases the clock-halted mode.
// - after such a release with acceptance enabled (and in-service set for priority 1), vectored servicing starts.
// - after such a release with acceptance disabled, the next instruction runs.
// - a release that leads to servicing waits 11 or 12 clocks first.
// - a release that leads to the next instruction waits 4 or 5 clocks first.
// - reset leaves the halted mode and restarts from the reset vector.
// - mask set keeps halt; priority 0 lets enable decide; priority 1 needs enable and in-service.
// - the deep-sleep instruction takes effect only while on the main system clock.
// - an unmasked pending request at deep-sleep entry drops to halt, resuming after stabilization.
// - deep sleep stops the cpu clock, fast and crystal oscillators, and ignores ext main clock.
// - deep sleep keeps xt1 and slow oscillator as they were; ext subsystem clock follows its pin.
// - deep sleep retains ram and port latches and stops cpu, flash and 16-bit timers.
// - halt stops the cpu and keeps ram, port latches and oscillators as they were.
`timescale 1ns/1ps
`default_nettype none
`include "standby_cfg.svh"
module standby_halt_stop_control (
    input wire logic clk,
    input wire logic rst,
    input wire logic haltInstr,
    input wire logic stopInstr,
    input wire logic cpuOnMainClk,
    input wire standby_pkg::irq_t irq,
    input wire logic irqAcceptEnable,
    input wire logic inServicePriorityFlag,
    input wire logic [`SHS_SEL_W-1:0] stabilizationWaitSelect,
    input wire standby_pkg::osc_req_t oscReq,
    input wire logic extSubClkIn,
    output var standby_pkg::clk_ctrl_t clkCtrl,
    output logic flashEn,
    output logic timer16En,
    output logic ramRetain,
    output logic portLatchHold,
    output logic halted,
    output logic stopped,
    output logic serviceStart,
    output logic resumeNext,
    output logic resetVectorStart
);
    import standby_pkg::*;

    // priority flag of the lowest-numbered pending unmasked source
    function automatic logic firstPrio(input logic [`SHS_IRQ_N-1:0] pend,
                                       input logic [`SHS_IRQ_N-1:0] prio);
        logic r;
        r = 1'h0;
        for (int i = `SHS_IRQ_N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                r = prio[i];
            end
        end
        return r;
    endfunction : firstPrio

    // stabilization wait: 2^(base+sel) clocks
    function automatic logic [`SHS_CNT_W-1:0] stabCount(input logic [`SHS_SEL_W-1:0] sel);
        return `SHS_CNT_W'(1) << (`SHS_STAB_LOG2_BASE + int'(sel));
    endfunction : stabCount

    standby_state_t state_reg, state_next;
    logic svc_reg, svc_next;
    logic [`SHS_IRQ_N-1:0] pend;
    logic wake, svcOk, timerDone, timerLoad, timerRun;
    logic [`SHS_CNT_W-1:0] loadVal;
    logic rstDly_reg, extSubS1_reg, extSubS2_reg;

    assign pend = irq.req & ~irq.irqMaskFlag;
    assign wake = |pend;
    // priority 0: enable decides; priority 1: enable and in-service both
    assign svcOk = firstPrio(pend, irq.irqPriorityFlag) ?
                   (irqAcceptEnable & inServicePriorityFlag) : irqAcceptEnable;

    always_comb begin
        state_next = state_reg;
        svc_next = svc_reg;
        case (state_reg)
            ST_RUN: begin
                if (haltInstr) begin
                    state_next = ST_HALT;
                end else if (stopInstr && cpuOnMainClk) begin
                    if (wake) begin
                        state_next = ST_STAB;
                        svc_next = svcOk;
                    end else begin
                        state_next = ST_STOP;
                    end
                end
            end
            ST_HALT: begin
                if (wake) begin
                    state_next = ST_WAIT;
                    svc_next = svcOk;
                end
            end
            ST_STOP: begin
                if (wake) begin
                    state_next = ST_STAB;
                    svc_next = svcOk;
                end
            end
            ST_WAIT, ST_STAB: begin
                if (timerDone) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    assign timerLoad = (state_next == ST_WAIT || state_next == ST_STAB) &&
                       (state_next != state_reg);
    assign timerRun = (state_reg == ST_WAIT || state_reg == ST_STAB);
    always_comb begin
        if (state_next == ST_STAB) begin
            loadVal = stabCount(stabilizationWaitSelect);
        end else if (svc_next) begin
            loadVal = `SHS_WAIT_SERVICE;
        end else begin
            loadVal = `SHS_WAIT_NEXT;
        end
    end

    wake_wait_timer waitTimer (
        .clk(clk),
        .rst(rst),
        .load(timerLoad),
        .loadVal(loadVal),
        .run(timerRun),
        .done(timerDone)
    );

    // sequencing state; reset returns to run
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_RUN;
            svc_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            svc_reg <= svc_next;
        end
    end

    // one-cycle outcome pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            serviceStart <= 1'h0;
            resumeNext <= 1'h0;
        end else begin
            serviceStart <= timerRun && timerDone && svc_reg;
            resumeNext <= timerRun && timerDone && !svc_reg;
        end
    end

    // reset vector start after reset release
    always_ff @(posedge clk) begin
        rstDly_reg <= rst;
        if (rst) begin
            resetVectorStart <= 1'h0;
        end else begin
            resetVectorStart <= rstDly_reg;
        end
    end

    // external subsystem clock pin synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            extSubS1_reg <= 1'h0;
            extSubS2_reg <= 1'h0;
        end else begin
            extSubS1_reg <= extSubClkIn;
            extSubS2_reg <= extSubS1_reg;
        end
    end

    // mode flags and memory/peripheral controls
    always_ff @(posedge clk) begin
        if (rst) begin
            halted <= 1'h0;
            stopped <= 1'h0;
            flashEn <= 1'h1;
            timer16En <= 1'h1;
            ramRetain <= 1'h0;
            portLatchHold <= 1'h0;
        end else begin
            halted <= (state_next == ST_HALT || state_next == ST_WAIT ||
                       state_next == ST_STAB);
            stopped <= (state_next == ST_STOP);
            flashEn <= (state_next == ST_RUN);
            timer16En <= (state_next != ST_STOP);
            ramRetain <= (state_next != ST_RUN);
            portLatchHold <= (state_next != ST_RUN);
        end
    end

    // clock gating and oscillator enables
    always_ff @(posedge clk) begin
        if (rst) begin
            clkCtrl <= '{cpuClkEn: 1'h1, internalFastOscEn: 1'h1, crystalMainEn: 1'h0,
                         extMainClkAccept: 1'h1, xt1En: 1'h0, internalSlowOscEn: 1'h1,
                         extSubClkOut: 1'h0};
        end else begin
            clkCtrl.cpuClkEn <= (state_next == ST_RUN);
            clkCtrl.extSubClkOut <= extSubS2_reg;
            if (state_next == ST_STOP) begin
                clkCtrl.internalFastOscEn <= 1'h0;
                clkCtrl.crystalMainEn <= 1'h0;
                clkCtrl.extMainClkAccept <= 1'h0;
            end else if (state_next != ST_HALT) begin
                clkCtrl.internalFastOscEn <= oscReq.internalFastOscRun;
                clkCtrl.crystalMainEn <= oscReq.crystalMainRun;
                clkCtrl.extMainClkAccept <= 1'h1;
            end
            // halt and stop keep the subsystem and slow oscillators as they were
            if (state_next == ST_RUN || state_next == ST_WAIT) begin
                clkCtrl.xt1En <= oscReq.xt1Run;
                clkCtrl.internalSlowOscEn <= oscReq.internalSlowOscRun;
            end
        end
    end

    property p_halt_entry;
        @(posedge clk) disable iff (rst)
        (state_reg == ST_RUN && haltInstr) |=> (halted && !clkCtrl.cpuClkEn);
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt entry missed");

    property p_wake_release;
        @(posedge clk) disable iff (rst)
        (state_reg == ST_HALT && wake) |=> (state_reg == ST_WAIT);
    endproperty
    a_wake_release: assert property (p_wake_release) else $error("halt not released");

    property p_masked_hold;
        @(posedge clk) disable iff (rst)
        (state_reg == ST_HALT && !wake) |=> (state_reg == ST_HALT && halted);
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("halt left while masked");

    property p_service_wait;
        @(posedge clk) disable iff (rst)
        (state_reg == ST_HALT && wake && svcOk)
            |-> !serviceStart [*8] ##1 !serviceStart [*4] ##1 serviceStart;
    endproperty
    a_service_wait: assert property (p_service_wait) else $error("service wait wrong");

    property p_next_wait;
        @(posedge clk) disable iff (rst)
        (state_reg == ST_HALT && wake && !svcOk) |-> ##5 (resumeNext && !serviceStart);
    endproperty
    a_next_wait: assert property (p_next_wait) else $error("next-instruction wait wrong");

    property p_stop_needs_main;
        @(posedge clk) disable iff (rst)
        (state_reg == ST_RUN && stopInstr && !haltInstr && !cpuOnMainClk) |=> !stopped;
    endproperty
    a_stop_needs_main: assert property (p_stop_needs_main) else $error("stop off main clk");

    property p_stop_fallback;
        @(posedge clk) disable iff (rst)
        (state_reg == ST_RUN && stopInstr && !haltInstr && cpuOnMainClk && wake)
            |=> (halted && !stopped && clkCtrl.internalFastOscEn == $past(oscReq.internalFastOscRun));
    endproperty
    a_stop_fallback: assert property (p_stop_fallback) else $error("stop fallback wrong");

    property p_stop_clocks;
        @(posedge clk) disable iff (rst)
        stopped |-> !(clkCtrl.cpuClkEn || clkCtrl.internalFastOscEn ||
                      clkCtrl.crystalMainEn || clkCtrl.extMainClkAccept);
    endproperty
    a_stop_clocks: assert property (p_stop_clocks) else $error("clock running in stop");

    property p_stop_keep_sub;
        @(posedge clk) disable iff (rst)
        (stopped && $past(stopped)) |-> ($stable(clkCtrl.xt1En) &&
                                         $stable(clkCtrl.internalSlowOscEn));
    endproperty
    a_stop_keep_sub: assert property (p_stop_keep_sub) else $error("sub osc changed in stop");

    property p_stop_memory;
        @(posedge clk) disable iff (rst)
        stopped |-> (!flashEn && !timer16En && ramRetain && portLatchHold);
    endproperty
    a_stop_memory: assert property (p_stop_memory) else $error("stop memory state wrong");

    property p_halt_keep;
        @(posedge clk) disable iff (rst)
        (state_reg == ST_HALT && $past(state_reg) == ST_HALT)
            |-> ($stable(clkCtrl.internalFastOscEn) && timer16En && ramRetain);
    endproperty
    a_halt_keep: assert property (p_halt_keep) else $error("halt state not kept");

    property p_reset_vector;
        @(posedge clk) disable iff (rst)
        $fell(rst) |=> (resetVectorStart && !halted && clkCtrl.cpuClkEn);
    endproperty
    a_reset_vector: assert property (p_reset_vector) else $error("no reset vector start");
endmodule : standby_halt_stop_control
`default_nettype wire

// file: shared/standby_cfg.svh
// standby sequencer constants: wait counts, widths, field sizes
// assumes inclusion by the standby package and by the modules and bench that use its macros
`ifndef STANDBY_CFG_SVH
`define STANDBY_CFG_SVH
`define SHS_IRQ_N 8
`define SHS_CNT_W 13
`define SHS_SEL_W 3
`define SHS_WAIT_SERVICE 13'h000B
`define SHS_WAIT_NEXT 13'h0004
`define SHS_STAB_LOG2_BASE 5
`endif

// file: shared/standby_pkg.sv
// types shared by the standby sequencer and its wait timer
// assumes standby_cfg.svh on the include path
`include "standby_cfg.svh"
package standby_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_HALT,
        ST_STOP,
        ST_WAIT,
        ST_STAB
    } standby_state_t;

    typedef struct packed {
        logic [`SHS_IRQ_N-1:0] req;
        logic [`SHS_IRQ_N-1:0] irqMaskFlag;
        logic [`SHS_IRQ_N-1:0] irqPriorityFlag;
    } irq_t;

    typedef struct packed {
        logic internalFastOscRun;
        logic crystalMainRun;
        logic xt1Run;
        logic internalSlowOscRun;
    } osc_req_t;

    typedef struct packed {
        logic cpuClkEn;
        logic internalFastOscEn;
        logic crystalMainEn;
        logic extMainClkAccept;
        logic xt1En;
        logic internalSlowOscEn;
        logic extSubClkOut;
    } clk_ctrl_t;
endpackage : standby_pkg

// file: core/wake_wait_timer.sv
// loadable down counter timing the release and stabilization waits
// assumes load and run come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "standby_cfg.svh"
module wake_wait_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [`SHS_CNT_W-1:0] loadVal,
    input wire logic run,
    output logic done
);
    import standby_pkg::*;

    logic [`SHS_CNT_W-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= `SHS_CNT_W'h0;
        end else if (load) begin
            cnt_reg <= loadVal;
        end else if (run && cnt_reg != `SHS_CNT_W'h0) begin
            cnt_reg <= cnt_reg - `SHS_CNT_W'h1;
        end
    end

    assign done = (cnt_reg == `SHS_CNT_W'h1);
endmodule : wake_wait_timer
`default_nettype wire

// file: testbench/cpu_irq_model.sv
// cpu core and interrupt controller model driving the standby sequencer
// assumes the bench shares clk and calls issue and raise
`timescale 1ns/1ps
`default_nettype none
`include "standby_cfg.svh"
module cpu_irq_model
    import standby_pkg::*;
(
    input wire logic clk,
    output logic haltInstr,
    output logic stopInstr,
    output logic cpuOnMainClk,
    output var standby_pkg::irq_t irq,
    output logic irqAcceptEnable,
    output logic inServicePriorityFlag
);
    // no pin-clocked peripheral is ever started from here
    initial begin
        haltInstr = 1'b0;
        stopInstr = 1'b0;
        cpuOnMainClk = 1'b1;
        irq = '0;
        irqAcceptEnable = 1'b0;
        inServicePriorityFlag = 1'b0;
    end
    // one-cycle halt or deep-sleep instruction
    task automatic issue(input logic halt, input logic mainClk);
        @(posedge clk);
        haltInstr <= halt;
        stopInstr <= ~halt;
        cpuOnMainClk <= mainClk;
        @(posedge clk);
        haltInstr <= 1'b0;
        stopInstr <= 1'b0;
    endtask : issue
    // request, mask and priority levels with acceptance flags
    task automatic raise(input logic [`SHS_IRQ_N-1:0] req, mask, prio, input logic ie, in_service_priority_flag);
        @(posedge clk);
        irq <= {req, mask, prio};
        irqAcceptEnable <= ie;
        inServicePriorityFlag <= in_service_priority_flag;
    endtask : raise
endmodule : cpu_irq_model
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the standby sequencer
// assumes cpu_irq_model drives the cpu and interrupt inputs
`timescale 1ns/1ps
`default_nettype none
`include "standby_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_top;
    import standby_pkg::*;
    localparam logic [2:0] SEL = 3'h1;
    localparam int W = 1 << (`SHS_STAB_LOG2_BASE + SEL);
    logic clk, rst, haltInstr, stopInstr, cpuOnMainClk, irqAcceptEnable;
    logic inServicePriorityFlag, extSubClkIn, flashEn, timer16En, ramRetain;
    logic portLatchHold, halted, stopped, serviceStart, resumeNext, resetVectorStart;
    logic [2:0] sel;
    irq_t irq;
    osc_req_t oscReq;
    clk_ctrl_t clkCtrl;
    int failures = 0;
    int n_compared = 0;
    logic [3:0] rows [5] = '{4'b0010, 4'b0101, 4'b1010, 4'b1100, 4'b1111};

    cpu_irq_model cpu_irq_model_i (.clk(clk), .haltInstr(haltInstr), .stopInstr(stopInstr),
        .cpuOnMainClk(cpuOnMainClk), .irq(irq), .irqAcceptEnable(irqAcceptEnable),
        .inServicePriorityFlag(inServicePriorityFlag));
    standby_halt_stop_control standby_halt_stop_control_i (.clk(clk), .rst(rst),
        .haltInstr(haltInstr), .stopInstr(stopInstr), .cpuOnMainClk(cpuOnMainClk),
        .irq(irq), .irqAcceptEnable(irqAcceptEnable),
        .inServicePriorityFlag(inServicePriorityFlag), .stabilizationWaitSelect(sel),
        .oscReq(oscReq), .extSubClkIn(extSubClkIn), .clkCtrl(clkCtrl), .flashEn(flashEn),
        .timer16En(timer16En), .ramRetain(ramRetain), .portLatchHold(portLatchHold),
        .halted(halted), .stopped(stopped), .serviceStart(serviceStart),
        .resumeNext(resumeNext), .resetVectorStart(resetVectorStart));

    always #5 clk = ~clk;

    task automatic close_out();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // counts clocks from the release edge to the resume pulse
    task automatic wait_pulse(input int lo, input int hi, input logic svc);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (serviceStart !== 1'b1 && resumeNext !== 1'b1 && n < hi + 10);
        `CHK(n - 1 >= lo && n - 1 <= hi, 1'b1)
        `CHK({serviceStart, resumeNext}, {svc, ~svc})
    endtask : wait_pulse

    task automatic t_reset(input logic inHalt);
        if (inHalt) begin
            cpu_irq_model_i.issue(1'b1, 1'b1);
            @(negedge clk);
            `CHK(halted, 1'b1)
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK({resetVectorStart, halted, stopped, clkCtrl.cpuClkEn}, 4'b1001)
        $display("test reset in halt %b done", inHalt);
    endtask : t_reset

    task automatic t_halt(input logic pr, ie, in_service_priority_flag, svc);
        cpu_irq_model_i.issue(1'b1, 1'b1);
        @(negedge clk);
        `CHK({halted, clkCtrl.cpuClkEn}, 2'b10)
        `CHK({flashEn, ramRetain, portLatchHold, timer16En}, 4'b0111)
        cpu_irq_model_i.raise(8'h01, 8'h01, {7'h00, pr}, ie, in_service_priority_flag);
        repeat (20) @(negedge clk);
        `CHK({halted, serviceStart, resumeNext}, 3'b100)
        cpu_irq_model_i.raise(8'h01, 8'h00, {7'h00, pr}, ie, in_service_priority_flag);
        if (svc) begin
            wait_pulse(11, 12, 1'b1);
        end else begin
            wait_pulse(4, 5, 1'b0);
        end
        `CHK({halted, clkCtrl.cpuClkEn}, 2'b01)
        cpu_irq_model_i.raise('0, '0, '0, 1'b0, 1'b0);
        $display("test halt pr %b ie %b isp %b done", pr, ie, in_service_priority_flag);
    endtask : t_halt

    task automatic t_stop();
        @(posedge clk);
        oscReq <= 4'b1110;
        cpu_irq_model_i.issue(1'b0, 1'b0);
        @(negedge clk);
        `CHK(stopped, 1'b0)
        cpu_irq_model_i.issue(1'b0, 1'b1);
        oscReq <= 4'b0001;
        extSubClkIn <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK(clkCtrl.extSubClkOut, 1'b0)
        @(negedge clk);
        `CHK(clkCtrl.extSubClkOut, 1'b1)
        `CHK(stopped, 1'b1)
        `CHK(clkCtrl[6:3], 4'b0000)
        `CHK(clkCtrl[2:1], 2'b10)
        `CHK({flashEn, timer16En, ramRetain, portLatchHold}, 4'b0011)
        cpu_irq_model_i.raise(8'h04, 8'h00, 8'h00, 1'b1, 1'b0);
        wait_pulse(W, W + 2, 1'b1);
        `CHK({stopped, halted}, 2'b00)
        cpu_irq_model_i.raise('0, '0, '0, 1'b0, 1'b0);
        $display("test stop done");
    endtask : t_stop

    task automatic t_stop_pending();
        cpu_irq_model_i.raise(8'h80, 8'h00, 8'h00, 1'b0, 1'b0);
        cpu_irq_model_i.issue(1'b0, 1'b1);
        @(negedge clk);
        `CHK({stopped, halted}, 2'b01)
        wait_pulse(W - 1, W + 2, 1'b0);
        cpu_irq_model_i.raise('0, '0, '0, 1'b0, 1'b0);
        $display("test stop with pending request done");
    endtask : t_stop_pending

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sel = SEL;
        oscReq = 4'b1111;
        extSubClkIn = 1'b0;
        t_reset(1'b0);
        foreach (rows[i]) begin
            t_halt(rows[i][3], rows[i][2], rows[i][1], rows[i][0]);
        end
        t_reset(1'b1);
        t_stop();
        t_stop_pending();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
